/* File: logic/mnsd_pkg.sv */
// Shared constants, types and helper functions of the instruction decode block.
package mnsd_pkg;

	// ****************************************
	// Widths and sizes
	// ****************************************
	localparam int unsigned PC_W = 21;
	localparam int unsigned FADDR_W = 12;
	localparam int unsigned STACK_DEPTH = 31;
	localparam int unsigned DEPTH_W = 5;
	localparam int unsigned REG_ADDR_W = 8;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_BANK = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PROD_LOW = 8'h10;
	localparam logic [7:0] OFS_PROD_HIGH = 8'h14;
	localparam logic [7:0] OFS_INDEX_BASE = 8'h18;
	localparam logic [7:0] OFS_STACK_INFO = 8'h1C;
	localparam logic [7:0] OFS_STACK_TOP = 8'h20;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned CTRL_EXT_EN_BIT = 0;
	localparam int unsigned ST_CARRY_BIT = 0;
	localparam int unsigned ST_HALF_CARRY_BIT = 1;
	localparam int unsigned ST_ZERO_BIT = 2;
	localparam int unsigned ST_RANGE_BIT = 3;
	localparam int unsigned ST_NEG_BIT = 4;
	localparam int unsigned INFO_FULL_BIT = 8;
	localparam int unsigned INFO_EMPTY_BIT = 9;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_BANK = 4'h0;
	localparam logic [4:0] RST_STATUS = 5'h00;
	localparam logic [11:0] RST_INDEX_BASE = 12'h000;

	// ****************************************
	// Encodings and address constants
	// ****************************************
	localparam logic [6:0] OPC_MUL_FILE = 7'h01;
	localparam logic [6:0] OPC_NEG_FILE = 7'h36;
	localparam logic [15:0] OPC_POP = 16'h0006;
	localparam logic [15:0] OPC_PUSH = 16'h0005;
	localparam logic [15:0] OPC_IDLE = 16'h0000;
	localparam logic [3:0] OPC_IDLE_NIBBLE = 4'hF;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
	localparam logic [20:0] PC_STEP = 21'h0_0002;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} mnsd_phase_t;
	typedef enum logic [2:0] {OP_IDLE, OP_MUL, OP_NEG, OP_POP, OP_PUSH, OP_OTHER} mnsd_op_t;

	// Classify one program word.
	function automatic mnsd_op_t mnsd_decode(input logic [15:0] w);
		mnsd_op_t op;
		op = OP_OTHER;
		if (w == OPC_IDLE || w[15:12] == OPC_IDLE_NIBBLE) begin
			op = OP_IDLE;
		end else if (w[15:9] == OPC_MUL_FILE) begin
			op = OP_MUL;
		end else if (w[15:9] == OPC_NEG_FILE) begin
			op = OP_NEG;
		end else if (w == OPC_POP) begin
			op = OP_POP;
		end else if (w == OPC_PUSH) begin
			op = OP_PUSH;
		end
		return op;
	endfunction : mnsd_decode

	// Two's complement of a byte.
	function automatic logic [7:0] mnsd_neg_value(input logic [7:0] v);
		return 8'(~v + 8'h01);
	endfunction : mnsd_neg_value

	// Flags after negation, packed in status bit order.
	function automatic logic [4:0] mnsd_neg_flags(input logic [7:0] v);
		logic [7:0] r;
		logic [4:0] f;
		r = mnsd_neg_value(v);
		f = 5'h00;
		f[ST_CARRY_BIT] = (v == 8'h00);
		f[ST_HALF_CARRY_BIT] = (v[3:0] == 4'h0);
		f[ST_ZERO_BIT] = (r == 8'h00);
		f[ST_RANGE_BIT] = (v == 8'h80);
		f[ST_NEG_BIT] = r[7];
		return f;
	endfunction : mnsd_neg_flags

endpackage : mnsd_pkg

/* File: logic/mnsd_stack_if.sv */
// Connection between the decode core and its return stack.
`timescale 1ns/100ps
interface mnsd_stack_if;
	import mnsd_pkg::*;
	logic push;
	logic pop;
	logic [PC_W-1:0] push_data;
	logic [PC_W-1:0] top;
	logic [PC_W-1:0] second;
	logic [DEPTH_W-1:0] depth;
	logic full;
	logic empty;
	modport core (output push, pop, push_data, input top, second, depth, full, empty);
	modport stack (input push, pop, push_data, output top, second, depth, full, empty);
endinterface : mnsd_stack_if

/* File: logic/mnsd_rstack.sv */
// Hardware return stack held in flip-flops.
`timescale 1ns/100ps
module mnsd_rstack
	import mnsd_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Core side.
	mnsd_stack_if.stack stk
);

	logic [PC_W-1:0] entry [STACK_DEPTH];
	logic [DEPTH_W-1:0] count;

	// ****************************************
	// Storage
	// ****************************************
	// A push writes above the old top, so older entries stay where they are.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			count <= '0;
		end else if (stk.push && !stk.full) begin
			entry[count] <= stk.push_data;
			count <= DEPTH_W'(count + 5'h01);
		end else if (stk.pop && !stk.empty) begin
			count <= DEPTH_W'(count - 5'h01);
		end
	end

	// Top and next entry; an empty slot reads as zero.
	assign stk.top = (count != '0) ? entry[DEPTH_W'(count - 5'h01)] : '0;
	assign stk.second = (count > 5'h01) ? entry[DEPTH_W'(count - 5'h02)] : '0;
	assign stk.depth = count;
	assign stk.full = (count == DEPTH_W'(STACK_DEPTH));
	assign stk.empty = (count == '0);

endmodule : mnsd_rstack

/* File: logic/mnsd_core.sv */
// Decode and execute core for multiply, negate, idle, pop and push.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module mnsd_core
	import mnsd_pkg::*;
(
	// Clock, reset and enable.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Register port.
	input wire logic [REG_ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	// Program memory side.
	input wire logic [15:0] i_instr_word,
	input wire logic i_instr_valid,
	input wire logic [PC_W-1:0] i_pc,
	output logic o_instr_ready,
	// Data register file side.
	output logic [FADDR_W-1:0] o_file_addr,
	output logic o_file_rd,
	input wire logic [7:0] i_file_rdata,
	output logic [7:0] o_file_wdata,
	output logic o_file_we
);

	mnsd_phase_t phase;
	mnsd_op_t op;
	logic take;
	logic bus_wr;
	logic [7:0] fsel;
	logic [PC_W-1:0] ret_addr;
	logic [FADDR_W-1:0] next_file_addr;
	logic [7:0] operand;
	logic [7:0] acc;
	logic [3:0] bank;
	logic [4:0] status;
	logic [7:0] prod_low;
	logic [7:0] prod_high;
	logic [FADDR_W-1:0] index_base;
	logic ext_en;
	logic indexed_sel;
	logic [31:0] next_rdata;

	mnsd_stack_if stk_if ();

	// ****************************************
	// Return stack
	// ****************************************
	mnsd_rstack u_rstack (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.stk(stk_if.stack)
	);

	// Stack actions happen in the write phase; a full stack ignores a push and an empty one a pop.
	assign stk_if.push = i_ce && phase == PH_WRITE && op == OP_PUSH;
	assign stk_if.pop = i_ce && phase == PH_WRITE && op == OP_POP;
	assign stk_if.push_data = ret_addr;

	// ****************************************
	// Phase sequencer
	// ****************************************
	assign take = phase == PH_DECODE && i_instr_valid;
	assign o_instr_ready = phase == PH_DECODE;

	// Each word runs decode, read, process and write, then the next is taken.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			phase <= PH_DECODE;
		end else if (i_ce) begin
			case (phase)
				PH_DECODE: begin
					if (i_instr_valid) begin
						phase <= PH_READ;
					end
				end
				PH_READ: begin
					phase <= PH_PROCESS;
				end
				PH_PROCESS: begin
					phase <= PH_WRITE;
				end
				PH_WRITE: begin
					phase <= PH_DECODE;
				end
				default: begin
					phase <= PH_DECODE;
				end
			endcase
		end
	end

	// ****************************************
	// Operand addressing
	// ****************************************
	// Indexed offset only applies to the low part of the access bank.
	assign indexed_sel = ext_en && !i_instr_word[8] && i_instr_word[7:0] <= INDEXED_LIMIT;

	always_comb begin
		if (i_instr_word[8]) begin
			next_file_addr = {bank, i_instr_word[7:0]};
		end else if (indexed_sel) begin
			next_file_addr = FADDR_W'(index_base + {4'h0, i_instr_word[7:0]});
		end else if (i_instr_word[7:0] < ACCESS_SPLIT) begin
			next_file_addr = {ACCESS_LOW_PAGE, i_instr_word[7:0]};
		end else begin
			next_file_addr = {ACCESS_HIGH_PAGE, i_instr_word[7:0]};
		end
	end

	// Latch the word, its address and the return address when it is taken.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			op <= OP_IDLE;
			fsel <= RST_BYTE;
			ret_addr <= '0;
			o_file_addr <= '0;
		end else if (i_ce && take) begin
			op <= mnsd_decode(i_instr_word);
			fsel <= i_instr_word[7:0];
			ret_addr <= PC_W'(i_pc + PC_STEP);
			o_file_addr <= next_file_addr;
		end
	end

	// ****************************************
	// Data file access
	// ****************************************
	// Read strobe stands for the read phase only, and only for file operands.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_file_rd <= 1'b0;
		end else if (i_ce) begin
			o_file_rd <= take && (mnsd_decode(i_instr_word) inside {OP_MUL, OP_NEG});
		end
	end

	// Read data is valid in the process phase, one cycle after the strobe.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			operand <= RST_BYTE;
		end else if (i_ce && phase == PH_PROCESS) begin
			operand <= i_file_rdata;
		end
	end

	// Only negate writes the file; multiply leaves its source alone.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_file_we <= 1'b0;
			o_file_wdata <= RST_BYTE;
		end else if (i_ce) begin
			o_file_we <= phase == PH_PROCESS && op == OP_NEG;
			if (phase == PH_PROCESS && op == OP_NEG) begin
				o_file_wdata <= mnsd_neg_value(i_file_rdata);
			end
		end
	end

	// ****************************************
	// Software registers and results
	// ****************************************
	assign bus_wr = i_ce && i_reg_wr;

	// Product pair; the multiply result wins over a software write.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			prod_low <= RST_BYTE;
			prod_high <= RST_BYTE;
		end else if (i_ce && phase == PH_WRITE && op == OP_MUL) begin
			{prod_high, prod_low} <= {8'h00, acc} * {8'h00, operand};
		end else if (bus_wr && i_reg_addr == OFS_PROD_LOW) begin
			prod_low <= i_reg_wdata[7:0];
		end else if (bus_wr && i_reg_addr == OFS_PROD_HIGH) begin
			prod_high <= i_reg_wdata[7:0];
		end
	end

	// Status changes only on negate or a software write; multiply never touches it.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			status <= RST_STATUS;
		end else if (i_ce && phase == PH_WRITE && op == OP_NEG) begin
			status <= mnsd_neg_flags(operand);
		end else if (bus_wr && i_reg_addr == OFS_STATUS) begin
			status <= i_reg_wdata[4:0];
		end
	end

	// Accumulator, bank pointer, index base and control are software owned.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			acc <= RST_BYTE;
			bank <= RST_BANK;
			index_base <= RST_INDEX_BASE;
			ext_en <= 1'b0;
		end else if (bus_wr) begin
			case (i_reg_addr)
				OFS_ACC: begin
					acc <= i_reg_wdata[7:0];
				end
				OFS_BANK: begin
					bank <= i_reg_wdata[3:0];
				end
				OFS_INDEX_BASE: begin
					index_base <= i_reg_wdata[FADDR_W-1:0];
				end
				OFS_CTRL: begin
					ext_en <= i_reg_wdata[CTRL_EXT_EN_BIT];
				end
				default: begin
					ext_en <= ext_en;
				end
			endcase
		end
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (i_reg_addr)
			OFS_CTRL: next_rdata[CTRL_EXT_EN_BIT] = ext_en;
			OFS_ACC: next_rdata[7:0] = acc;
			OFS_BANK: next_rdata[3:0] = bank;
			OFS_STATUS: next_rdata[4:0] = status;
			OFS_PROD_LOW: next_rdata[7:0] = prod_low;
			OFS_PROD_HIGH: next_rdata[7:0] = prod_high;
			OFS_INDEX_BASE: next_rdata[FADDR_W-1:0] = index_base;
			OFS_STACK_INFO: begin
				next_rdata[DEPTH_W-1:0] = stk_if.depth;
				next_rdata[INFO_FULL_BIT] = stk_if.full;
				next_rdata[INFO_EMPTY_BIT] = stk_if.empty;
			end
			OFS_STACK_TOP: next_rdata[PC_W-1:0] = stk_if.top;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data stands for one enabled cycle after the strobe; a cycle with the enable low holds it.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_ce) begin
			o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	// Frozen cycles are invisible to the checks, so the enable gates the clock.
	default clocking cb @(posedge i_core_clk iff i_ce);
	endclocking
	default disable iff (i_sys_rst);

	chk_mul_product: assert property (
		phase == PH_WRITE && op == OP_MUL |=> {prod_high, prod_low} == $past(acc) * $past(operand)
	) else $error("product pair does not hold the multiply result");

	chk_mul_keeps: assert property (
		phase == PH_WRITE && op == OP_MUL && !bus_wr
			|-> !o_file_we ##1 $stable(acc) && $stable(status)
	) else $error("multiply changed accumulator, file or flags");

	chk_no_zero_flag: assert property (
		phase == PH_WRITE && op == OP_MUL && operand == 8'h00 && !bus_wr |=> status == $past(status)
	) else $error("zero product changed the flags");

	chk_bank_addr: assert property (
		take && i_instr_word[8] |=> o_file_addr == {$past(bank), $past(i_instr_word[7:0])}
	) else $error("bank pointer not used for bank bit one");

	chk_indexed_addr: assert property (
		take && ext_en && !i_instr_word[8] && i_instr_word[7:0] <= INDEXED_LIMIT
			|=> o_file_addr == FADDR_W'($past(index_base) + {4'h0, $past(i_instr_word[7:0])})
	) else $error("indexed offset address wrong");

	chk_neg_write: assert property (
		phase == PH_PROCESS && op == OP_NEG
			|=> o_file_we && o_file_wdata == mnsd_neg_value($past(i_file_rdata)) ##1 !o_file_we
	) else $error("negate result not written back");

	chk_neg_same_addr: assert property (
		phase == PH_READ && op == OP_NEG |-> o_file_rd ##2 o_file_we && $stable(o_file_addr)
	) else $error("negate did not write back to the location it read");

	chk_neg_flags: assert property (
		phase == PH_WRITE && op == OP_NEG |=> status == mnsd_neg_flags($past(operand))
	) else $error("negate flags wrong");

	chk_pop_top: assert property (
		stk_if.pop && stk_if.depth > 5'h01 |=> stk_if.top == $past(stk_if.second)
	) else $error("pop did not expose previous entry");

	chk_pop_quiet: assert property (
		phase == PH_WRITE && op == OP_POP && !bus_wr |-> !o_file_we ##1 $stable(status)
	) else $error("pop wrote a register or flag");

	chk_push_top: assert property (
		take && mnsd_decode(i_instr_word) == OP_PUSH && !stk_if.full
			|-> ##3 stk_if.push ##1 stk_if.top == PC_W'($past(i_pc, 4) + PC_STEP)
	) else $error("push did not place program counter plus two");

	chk_push_keep: assert property (
		stk_if.push && !stk_if.full && !stk_if.empty |=> stk_if.second == $past(stk_if.top)
	) else $error("push lost the former top");

	// A full stack must ignore the push rather than overwrite its top.
	chk_full_push: assert property (
		stk_if.push && stk_if.full |=> $stable(stk_if.top) && $stable(stk_if.depth)
	) else $error("push into a full stack disturbed it");

	chk_four_phase: assert property (
		take |=> phase == PH_READ ##1 phase == PH_PROCESS ##1 phase == PH_WRITE ##1 o_instr_ready
	) else $error("instruction did not take four phases");

	chk_idle_quiet: assert property (
		phase == PH_WRITE && op == OP_IDLE && !bus_wr
			|-> !o_file_we && !stk_if.push && !stk_if.pop
			##1 $stable(status) && $stable({prod_high, prod_low})
	) else $error("idle word caused an action");

	cov_mul: cover property (phase == PH_WRITE && op == OP_MUL);
	cov_neg: cover property (phase == PH_WRITE && op == OP_NEG && operand == 8'h80);
	cov_push_pop: cover property (stk_if.push ##[4:12] stk_if.pop);
	cov_indexed: cover property (take && indexed_sel);

endmodule : mnsd_core

/* File: test/mnsd_file_model.sv */
// Behavioural data register file that answers the decode core's file strobes.
`timescale 1ns/100ps
module mnsd_file_model
	import mnsd_pkg::*;
(
	// Clock.
	input wire logic i_core_clk,
	// Core side.
	input wire logic [FADDR_W-1:0] i_file_addr,
	input wire logic i_file_rd,
	input wire logic [7:0] i_file_wdata,
	input wire logic i_file_we,
	output logic [7:0] o_file_rdata
);
	// ****************************************
	// Storage and read path
	// ****************************************
	logic [7:0] mem [0:4095];
	logic [7:0] rdata_q = 8'h5A;

	// Data stand only in the cycle after the strobe; otherwise the bus toggles
	// every cycle, so a core that samples late sees garbage, not a stale byte.
	always @(posedge i_core_clk) begin
		if (i_file_rd) begin
			rdata_q <= mem[i_file_addr];
		end else begin
			rdata_q <= ~rdata_q;
		end
	end

	// Writes land at the edge that ends the strobe cycle.
	always @(posedge i_core_clk) begin
		if (i_file_we) begin
			mem[i_file_addr] <= i_file_wdata;
		end
	end

	assign o_file_rdata = rdata_q;
endmodule : mnsd_file_model

/* File: test/tb_top.sv */
// Self-checking bench for the decode core against an integer reference model.
`timescale 1ns/100ps
module tb_top;
	import mnsd_pkg::*;
	// ****************************************
	// Signals and model state
	// ****************************************
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_ce = 1'b1;
	logic [7:0] i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0000_0000;
	logic i_reg_wr = 1'b0;
	logic i_reg_rd = 1'b0;
	logic [31:0] o_reg_rdata;
	logic [15:0] i_instr_word = 16'h0000;
	logic i_instr_valid = 1'b0;
	logic [20:0] i_pc = 21'h00_0000;
	logic o_instr_ready;
	logic [11:0] o_file_addr, rd_a, we_a;
	logic o_file_rd, o_file_we;
	logic [7:0] i_file_rdata, o_file_wdata, we_d;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	int rd_n, we_n, acc, bank, ext, ibase, st, pl, ph;
	int stk[$];

	// ****************************************
	// Clock, instances and monitors
	// ****************************************
	initial begin
		forever #2 i_core_clk = ~i_core_clk;
	end

	mnsd_core mnsd_core_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_instr_word(i_instr_word),
		.i_instr_valid(i_instr_valid), .i_pc(i_pc), .o_instr_ready(o_instr_ready),
		.o_file_addr(o_file_addr), .o_file_rd(o_file_rd), .i_file_rdata(i_file_rdata),
		.o_file_wdata(o_file_wdata), .o_file_we(o_file_we));

	mnsd_file_model mnsd_file_model_i (.i_core_clk(i_core_clk), .i_file_addr(o_file_addr),
		.i_file_rd(o_file_rd), .i_file_wdata(o_file_wdata), .i_file_we(o_file_we),
		.o_file_rdata(i_file_rdata));

	// Count file strobes so that a stray read or write shows up in the totals.
	always @(posedge i_core_clk) begin
		if (o_file_rd === 1'b1 && i_ce) begin
			rd_n++;
			rd_a = o_file_addr;
		end
		if (o_file_we === 1'b1 && i_ce) begin
			we_n++;
			we_a = o_file_addr;
			we_d = o_file_wdata;
		end
	end

	// A hang is cut short well beyond the few thousand cycles the run needs.
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic close_out();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
	endtask : reg_wr

	// The read data stand only in the cycle after the strobe, so sample there.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge i_core_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_core_clk);
		i_reg_rd <= 1'b0;
		#1;
		chk(what, exp, o_reg_rdata);
	endtask : rd_chk

	task automatic check_state();
		int n;
		n = stk.size();
		rd_chk(OFS_ACC, acc, "acc");
		rd_chk(OFS_STATUS, st, "status");
		rd_chk(OFS_PROD_LOW, pl, "prod low");
		rd_chk(OFS_PROD_HIGH, ph, "prod high");
		rd_chk(OFS_STACK_INFO, n | ((n == 31) << 8) | ((n == 0) << 9), "stack info");
		if (n > 0) begin
			rd_chk(OFS_STACK_TOP, stk[0], "stack top");
		end
	endtask : check_state

	// Hand one word over, then count the cycles until the core takes another.
	// A stall drops the enable for one cycle after the take; frozen cycles do not count.
	task automatic run_instr(input logic [15:0] w, input logic [20:0] pc, input bit stall);
		int cnt;
		rd_n = 0;
		we_n = 0;
		@(posedge i_core_clk);
		i_instr_valid <= 1'b1;
		i_instr_word <= w;
		i_pc <= pc;
		@(posedge i_core_clk);
		i_instr_valid <= 1'b0;
		i_ce <= !stall;
		if (stall) begin
			@(posedge i_core_clk);
			i_ce <= 1'b1;
		end
		cnt = 0;
		#1;
		while (o_instr_ready !== 1'b1 && cnt < 10) begin
			@(posedge i_core_clk);
			#1;
			cnt++;
		end
		chk("ready gap", 3, cnt);
	endtask : run_instr

	function automatic int exp_addr(input int a, input int f);
		if (a == 1) return (bank << 8) | f;
		if (ext == 1 && f <= 8'h5F) return (ibase + f) & 12'hFFF;
		if (f < 8'h80) return f;
		return 12'hF00 | f;
	endfunction : exp_addr

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] offs [9] = '{OFS_CTRL, OFS_ACC, OFS_BANK, OFS_STATUS, OFS_PROD_LOW,
			OFS_PROD_HIGH, OFS_INDEX_BASE, OFS_STACK_INFO, OFS_STACK_TOP};
		int masks [7] = '{8'h01, 8'hFF, 8'h0F, 8'h1F, 8'hFF, 8'hFF, 12'hFFF};
		int edge_f [4] = '{8'h5F, 8'h60, 8'h7F, 8'h80};
		int edge_v [4] = '{8'h00, 8'h80, 8'hF0, 8'h01};
		int f, v, a, op, r, p, ea, pcv, x;
		logic [15:0] w;
		void'($urandom(6441));
		repeat (5) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		// Reset values, read-write masks, a read-only place and an unmapped one.
		for (int i = 0; i < 9; i++) begin
			rd_chk(offs[i], (i == 7) ? 32'h0000_0200 : 32'h0000_0000, "reset value");
		end
		for (int i = 0; i < 7; i++) begin
			x = $urandom();
			reg_wr(offs[i], x);
			rd_chk(offs[i], x & masks[i], "rw mask");
		end
		reg_wr(OFS_STACK_INFO, 32'hFFFF_FFFF);
		rd_chk(OFS_STACK_INFO, 32'h0000_0200, "ro info");
		reg_wr(8'h24, 32'hFFFF_FFFF);
		rd_chk(8'h24, 32'h0000_0000, "unmapped");
		reg_wr(OFS_PROD_LOW, 32'h0000_0000);
		reg_wr(OFS_PROD_HIGH, 32'h0000_0000);
		pl = 0;
		ph = 0;
		// Random mix of all five instructions, biased towards boundary operands.
		for (int n = 0; n < 80; n++) begin
			acc = $urandom_range(0, 255);
			bank = $urandom_range(0, 15);
			ext = $urandom_range(0, 1);
			ibase = $urandom_range(0, 4095);
			st = $urandom_range(0, 31);
			reg_wr(OFS_ACC, acc);
			reg_wr(OFS_BANK, bank);
			reg_wr(OFS_CTRL, ext);
			reg_wr(OFS_INDEX_BASE, ibase);
			reg_wr(OFS_STATUS, st);
			f = ($urandom_range(0, 3) == 0) ? edge_f[$urandom_range(0, 3)] : $urandom_range(0, 255);
			v = ($urandom_range(0, 3) == 0) ? edge_v[$urandom_range(0, 3)] : $urandom_range(0, 255);
			a = $urandom_range(0, 1);
			pcv = $urandom_range(0, 2097151);
			op = $urandom_range(0, 5);
			ea = exp_addr(a, f);
			r = (256 - v) & 8'hFF;
			mnsd_file_model_i.mem[ea] = v[7:0];
			case (op)
				0: begin
					w = {OPC_MUL_FILE, a[0], f[7:0]};
					p = acc * v;
					pl = p & 8'hFF;
					ph = p >> 8;
				end
				1: begin
					w = {OPC_NEG_FILE, a[0], f[7:0]};
					st = (v == 0) | ((v % 16 == 0) << 1) | ((r == 0) << 2) | ((v == 128) << 3);
					st = st | ((r >> 7) << 4);
				end
				2: begin
					w = OPC_POP;
					if (stk.size() > 0) void'(stk.pop_front());
				end
				3: begin
					w = OPC_PUSH;
					if (stk.size() < 31) stk.push_front((pcv + 2) & 21'h1F_FFFF);
				end
				4: w = 16'h0000;
				default: w = {4'hF, 12'($urandom())};
			endcase
			run_instr(w, pcv[20:0], $urandom_range(0, 3) == 0);
			chk("file reads", op < 2, rd_n);
			chk("file writes", op == 1, we_n);
			chk("file byte", (op == 1) ? r : v, mnsd_file_model_i.mem[ea]);
			if (op < 2) chk("read addr", ea, rd_a);
			if (op == 1) chk("write addr", ea, we_a);
			if (op == 1) chk("write data", r, we_d);
			check_state();
		end
		// Fill the stack past its depth, then drain it past empty.
		for (int n = 0; n < 33; n++) begin
			run_instr(OPC_PUSH, 21'(n * 4), n[0]);
			if (stk.size() < 31) stk.push_front(n * 4 + 2);
			check_state();
		end
		for (int n = 0; n < 33; n++) begin
			run_instr(OPC_POP, 21'h00_0000, 1'b0);
			if (stk.size() > 0) void'(stk.pop_front());
			check_state();
		end
		close_out();
	end
endmodule : tb_top
